// ---- logic/dup_dev.sv ----
`timescale 1ns/1ns
// Operation
// - channel A select low routes to A
// - channel B select low routes to B
// - printer select low opens printer registers
// - direction pin low: I/O select register governs
// - direction pin high: control bit 5 governs
// - direction by control bit or AA/55
// - eight-bit bus, released unless driving read
// - data bit 0 is least significant
// - address bits 0-2 select the channel register, bits 0-1 the printer register
// - printer pulls acknowledge low on accept
// - printer raises busy while not ready
// - auto line feed is open-drain, low active
// - one external clock runs everything
// - read strobe fall places register on bus
// - write strobe fall loads addressed register
// - read-active high while CPU reads
// - master reset clears registers and outputs, but drives channel reset high
module dup_dev (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       srst_in,
  // host bus
  dup_bus_if.dev                          bus,
  // printer side
  input  wire logic                       direction_source_select_in,
  input  wire logic [dup_pkg::DUP_DW-1:0] printer_data_lines_in,
  output logic      [dup_pkg::DUP_DW-1:0] printer_data_lines_out,
  output logic                            printer_data_lines_oe_n_out,
  input  wire logic                       ack_n_in,
  input  wire logic                       busy_in,
  input  wire logic                       auto_line_feed_n_in,
  output logic                            auto_line_feed_n_out,
  output logic                            auto_line_feed_n_oe_n_out,
  // uart channel register port
  output logic                            uart_wr_out,
  output logic                            uart_rd_out,
  output logic                            uart_chan_b_out,
  output logic      [dup_pkg::DUP_AW-1:0] uart_addr_out,
  output logic      [dup_pkg::DUP_DW-1:0] uart_wdata_out,
  input  wire logic [dup_pkg::DUP_DW-1:0] uart_rdata_in,
  output logic                            uart_reset_out
);
  import dup_pkg::*;

  // ----------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------
  localparam int SW = 6 + DUP_AW + 2 * DUP_DW + 3;
  localparam logic [SW-1:0] SYNC_RST = {6'h3F, {DUP_AW{1'b0}},
                                        {DUP_DW{1'b0}}, {DUP_DW{1'b0}},
                                        3'h3};

  logic [SW-1:0]     sync_d;
  logic [SW-1:0]     sync_q;
  logic              csa_n_s;
  logic              csb_n_s;
  logic              csp_n_s;
  logic              rd_n_s;
  logic              wr_n_s;
  logic              mrst_n_s;
  logic [DUP_AW-1:0] addr_s;
  logic [DUP_DW-1:0] data_s;
  logic [DUP_DW-1:0] pd_s;
  logic              ack_n_s;
  logic              busy_s;
  logic              dir_src_s;

  assign sync_d = {bus.chan_a_select_n, bus.chan_b_select_n,
                   bus.printer_port_select_n, bus.read_strobe_n,
                   bus.write_strobe_n, bus.master_reset_n, bus.addr,
                   bus.host_data_bus, printer_data_lines_in,
                   ack_n_in, busy_in, direction_source_select_in};

  dup_sync #(
    .W   (SW),
    .RST (SYNC_RST)
  ) u_sync (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .d_in    (sync_d),
    .q_out   (sync_q)
  );

  assign {csa_n_s, csb_n_s, csp_n_s, rd_n_s, wr_n_s, mrst_n_s, addr_s,
          data_s, pd_s, ack_n_s, busy_s, dir_src_s} = sync_q;

  // ----------------------------------------------------------------------
  // strobe edges and select decode
  // ----------------------------------------------------------------------
  logic rd_n_q_reg;
  logic wr_n_q_reg;
  logic rst_all;
  logic rd_fall;
  logic wr_fall;
  logic sel_a;
  logic sel_b;
  logic sel_p;
  logic sel_uart;

  assign rst_all  = srst_in | ~mrst_n_s;
  assign rd_fall  = rd_n_q_reg & ~rd_n_s;
  assign wr_fall  = wr_n_q_reg & ~wr_n_s;
  assign sel_a    = ~csa_n_s & csb_n_s & csp_n_s;
  assign sel_b    = csa_n_s & ~csb_n_s & csp_n_s;
  assign sel_p    = csa_n_s & csb_n_s & ~csp_n_s;
  assign sel_uart = sel_a | sel_b;

  always_ff @(posedge clk_in) begin
    if (rst_all) begin
      rd_n_q_reg <= 1'b1;
      wr_n_q_reg <= 1'b1;
    end else begin
      rd_n_q_reg <= rd_n_s;
      wr_n_q_reg <= wr_n_s;
    end
  end

  // ----------------------------------------------------------------------
  // printer port registers
  // ----------------------------------------------------------------------
  logic [DUP_DW-1:0] pdata_reg;
  logic [DUP_DW-1:0] ctrl_reg;
  logic              iosel_in_reg;
  logic              dir_in;
  logic              pp_wr;
  logic [1:0]        pp_off;
  logic [DUP_DW-1:0] pp_rdata;
  logic [DUP_DW-1:0] stat_val;

  assign pp_off = addr_s[1:0];
  assign pp_wr  = wr_fall & sel_p;
  // high means printer lines are inputs
  assign dir_in = dir_src_s ? ctrl_reg[DUP_CTRL_DIR_BIT]
                            : iosel_in_reg;

  always_comb begin
    stat_val = '0;
    stat_val[DUP_STAT_BUSY_BIT] = busy_s;
    stat_val[DUP_STAT_ACK_BIT]  = ack_n_s;
  end

  assign pp_rdata = (pp_off == DUP_PP_DATA) ? (dir_in ? pd_s : pdata_reg) :
                    (pp_off == DUP_PP_STAT) ? stat_val :
                    (pp_off == DUP_PP_CTRL) ? ctrl_reg :
                    {{(DUP_DW-1){1'b0}}, iosel_in_reg};

  always_ff @(posedge clk_in) begin
    if (rst_all) begin
      pdata_reg    <= DUP_PDATA_RST;
      ctrl_reg     <= DUP_CTRL_RST;
      iosel_in_reg <= DUP_IOSEL_IN_RST;
    end else if (pp_wr) begin
      if (pp_off == DUP_PP_DATA) begin
        pdata_reg <= data_s;
      end
      if (pp_off == DUP_PP_CTRL) begin
        ctrl_reg <= data_s;
      end
      if (pp_off == DUP_PP_IOSEL && data_s == DUP_IOSEL_OUT) begin
        iosel_in_reg <= 1'b0;
      end
      if (pp_off == DUP_PP_IOSEL && data_s == DUP_IOSEL_IN) begin
        iosel_in_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // printer pins
  // ----------------------------------------------------------------------
  assign auto_line_feed_n_out = 1'b0;

  always_ff @(posedge clk_in) begin
    if (rst_all) begin
      printer_data_lines_out      <= DUP_PDATA_RST;
      printer_data_lines_oe_n_out <= 1'b1;
      auto_line_feed_n_oe_n_out   <= 1'b1;
    end else begin
      printer_data_lines_out      <= pdata_reg;
      printer_data_lines_oe_n_out <= dir_in;
      auto_line_feed_n_oe_n_out   <= ~ctrl_reg[DUP_CTRL_ALF_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // uart channel port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_all) begin
      uart_wr_out     <= 1'b0;
      uart_rd_out     <= 1'b0;
      uart_chan_b_out <= 1'b0;
      uart_addr_out   <= '0;
      uart_wdata_out  <= '0;
      uart_reset_out  <= 1'b1;
    end else begin
      uart_wr_out     <= wr_fall & sel_uart;
      uart_rd_out     <= rd_fall & sel_uart;
      uart_chan_b_out <= sel_b;
      uart_addr_out   <= addr_s;
      uart_wdata_out  <= data_s;
      uart_reset_out  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read data return
  // ----------------------------------------------------------------------
  logic              uart_pend_reg;
  logic [DUP_DW-1:0] rdata_reg;
  logic              oe_n_reg;
  logic              ract_reg;

  always_ff @(posedge clk_in) begin
    if (rst_all || rd_n_s) begin
      uart_pend_reg <= 1'b0;
      oe_n_reg      <= 1'b1;
      ract_reg      <= 1'b0;
      rdata_reg     <= '0;
    end else if (rd_fall && sel_p) begin
      rdata_reg     <= pp_rdata;
      oe_n_reg      <= 1'b0;
      ract_reg      <= 1'b1;
    end else if (rd_fall && sel_uart) begin
      uart_pend_reg <= 1'b1;
    end else if (uart_pend_reg && !uart_rd_out) begin
      // channel data valid the cycle after the read pulse
      uart_pend_reg <= 1'b0;
      rdata_reg     <= uart_rdata_in;
      oe_n_reg      <= 1'b0;
      ract_reg      <= 1'b1;
    end
  end

  assign bus.dev_data_out    = rdata_reg;
  assign bus.dev_data_oe_n   = oe_n_reg;
  assign bus.read_active_out = ract_reg;

endmodule : dup_dev

// ---- common/dup_pkg.sv ----
package dup_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int DUP_DW = 8;
  localparam int DUP_AW = 3;

  // ----------------------------------------------------------------------
  // printer port register offsets (two address bits)
  // ----------------------------------------------------------------------
  localparam logic [1:0] DUP_PP_DATA  = 2'h0;
  localparam logic [1:0] DUP_PP_STAT  = 2'h1;
  localparam logic [1:0] DUP_PP_CTRL  = 2'h2;
  localparam logic [1:0] DUP_PP_IOSEL = 2'h3;

  // ----------------------------------------------------------------------
  // printer field positions, patterns and reset values
  // ----------------------------------------------------------------------
  localparam int         DUP_CTRL_ALF_BIT  = 1;
  localparam int         DUP_CTRL_DIR_BIT  = 5;
  localparam int         DUP_STAT_ACK_BIT  = 6;
  localparam int         DUP_STAT_BUSY_BIT = 7;
  localparam logic [7:0] DUP_IOSEL_OUT     = 8'hAA;
  localparam logic [7:0] DUP_IOSEL_IN      = 8'h55;
  localparam logic [7:0] DUP_PDATA_RST     = 8'h00;
  localparam logic [7:0] DUP_CTRL_RST      = 8'h00;
  localparam logic       DUP_IOSEL_IN_RST  = 1'b0;

  // ----------------------------------------------------------------------
  // host controller register offsets and fields
  // ----------------------------------------------------------------------
  localparam logic [2:0] DUP_HR_ADDR   = 3'h0;
  localparam logic [2:0] DUP_HR_WDATA  = 3'h1;
  localparam logic [2:0] DUP_HR_GO     = 3'h2;
  localparam logic [2:0] DUP_HR_STATUS = 3'h3;
  localparam logic [2:0] DUP_HR_RDATA  = 3'h4;
  localparam int         DUP_HR_TGT_LSB = 3;
  localparam int         DUP_HR_RST_BIT = 7;
  localparam int         DUP_HR_GO_WR_BIT = 0;
  localparam int         DUP_HR_ST_BUSY_BIT = 0;
  localparam int         DUP_HR_ST_DONE_BIT = 1;
  localparam logic [7:0] DUP_HR_ADDR_RST = 8'h00;

  // ----------------------------------------------------------------------
  // host strobe timing
  // ----------------------------------------------------------------------
  localparam int DUP_CLK_NS    = 4;
  localparam int DUP_SETUP_NS  = 8;
  localparam int DUP_STROBE_NS = 40;
  localparam int DUP_HOLD_NS   = 8;
  localparam int DUP_SETUP_CYC  = (DUP_SETUP_NS + DUP_CLK_NS - 1) / DUP_CLK_NS;
  localparam int DUP_STROBE_CYC = (DUP_STROBE_NS + DUP_CLK_NS - 1) / DUP_CLK_NS;
  localparam int DUP_HOLD_CYC   = (DUP_HOLD_NS + DUP_CLK_NS - 1) / DUP_CLK_NS;

  // ----------------------------------------------------------------------
  // access targets
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DUP_TGT_A = 2'h0,
    DUP_TGT_B = 2'h1,
    DUP_TGT_P = 2'h2
  } dup_tgt_t;

endpackage : dup_pkg

// ---- common/dup_bus_if.sv ----
`timescale 1ns/1ns
interface dup_bus_if;
  logic                       chan_a_select_n;
  logic                       chan_b_select_n;
  logic                       printer_port_select_n;
  logic [dup_pkg::DUP_AW-1:0] addr;
  logic                       read_strobe_n;
  logic                       write_strobe_n;
  logic                       master_reset_n;
  logic [dup_pkg::DUP_DW-1:0] host_data_out;
  logic                       host_data_oe_n;
  logic [dup_pkg::DUP_DW-1:0] dev_data_out;
  logic                       dev_data_oe_n;
  logic                       read_active_out;
  wire  [dup_pkg::DUP_DW-1:0] host_data_bus;

  // resolved bus level, pulled high when nobody drives
  assign host_data_bus = !host_data_oe_n ? host_data_out :
                         !dev_data_oe_n  ? dev_data_out  : 8'hFF;

  modport host (
    output chan_a_select_n, chan_b_select_n, printer_port_select_n,
    output addr, read_strobe_n, write_strobe_n, master_reset_n,
    output host_data_out, host_data_oe_n,
    input  host_data_bus, read_active_out
  );

  modport dev (
    input  chan_a_select_n, chan_b_select_n, printer_port_select_n,
    input  addr, read_strobe_n, write_strobe_n, master_reset_n,
    input  host_data_bus,
    output dev_data_out, dev_data_oe_n, read_active_out
  );
endinterface : dup_bus_if

// ---- logic/dup_sync.sv ----
`timescale 1ns/1ns
module dup_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_reg <= RST;
      q_out    <= RST;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule : dup_sync

// ---- logic/dup_host.sv ----
`timescale 1ns/1ns
module dup_host (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       srst_in,
  // register port
  input  wire logic [2:0]                 reg_addr_in,
  input  wire logic [dup_pkg::DUP_DW-1:0] reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic      [dup_pkg::DUP_DW-1:0] reg_rdata_out,
  // device bus
  dup_bus_if.host                         bus
);
  import dup_pkg::*;

  typedef enum logic [3:0] {
    DUP_H_IDLE  = 4'h1,
    DUP_H_SETUP = 4'h2,
    DUP_H_STRB  = 4'h4,
    DUP_H_HOLD  = 4'h8
  } dup_hstate_t;

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  logic [DUP_DW-1:0] addr_cfg_reg;
  logic [DUP_DW-1:0] wdata_reg;
  logic [DUP_DW-1:0] rdata_reg;
  logic              is_wr_reg;
  logic              done_reg;
  dup_hstate_t       state_reg;
  dup_hstate_t       state_next;
  logic [7:0]        cnt_reg;
  logic              busy;
  logic              go;
  logic              finish;
  logic              cnt_last;
  logic              strb_last;
  logic [DUP_DW-1:0] status_val;
  logic [DUP_DW-1:0] rd_mux;
  dup_tgt_t          tgt;

  assign busy   = state_reg != DUP_H_IDLE;
  assign go     = reg_wr_in && reg_addr_in == DUP_HR_GO && !busy;
  assign tgt    = dup_tgt_t'(addr_cfg_reg[DUP_HR_TGT_LSB +: 2]);
  assign finish = state_reg == DUP_H_HOLD && cnt_last;
  assign strb_last = state_reg == DUP_H_STRB && cnt_last;

  always_comb begin
    status_val = '0;
    status_val[DUP_HR_ST_BUSY_BIT] = busy;
    status_val[DUP_HR_ST_DONE_BIT] = done_reg;
  end

  assign rd_mux = (reg_addr_in == DUP_HR_ADDR)   ? addr_cfg_reg :
                  (reg_addr_in == DUP_HR_WDATA)  ? wdata_reg :
                  (reg_addr_in == DUP_HR_STATUS) ? status_val :
                  (reg_addr_in == DUP_HR_RDATA)  ? rdata_reg : 8'h00;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      addr_cfg_reg  <= DUP_HR_ADDR_RST;
      wdata_reg     <= '0;
      is_wr_reg     <= 1'b0;
      done_reg      <= 1'b0;
      reg_rdata_out <= '0;
    end else begin
      if (reg_wr_in && reg_addr_in == DUP_HR_ADDR) begin
        addr_cfg_reg <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == DUP_HR_WDATA) begin
        wdata_reg <= reg_wdata_in;
      end
      if (go) begin
        is_wr_reg <= reg_wdata_in[DUP_HR_GO_WR_BIT];
      end
      // completion wins over a status read in the same cycle
      if (finish) begin
        done_reg <= 1'b1;
      end else if (reg_rd_in && reg_addr_in == DUP_HR_STATUS) begin
        done_reg <= 1'b0;
      end
      reg_rdata_out <= reg_rd_in ? rd_mux : '0;
    end
  end

  // ----------------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------------
  assign cnt_last =
    (state_reg == DUP_H_SETUP && cnt_reg == 8'(DUP_SETUP_CYC - 1)) ||
    (state_reg == DUP_H_STRB  && cnt_reg == 8'(DUP_STROBE_CYC - 1)) ||
    (state_reg == DUP_H_HOLD  && cnt_reg == 8'(DUP_HOLD_CYC - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DUP_H_IDLE:  state_next = go ? DUP_H_SETUP : DUP_H_IDLE;
      DUP_H_SETUP: state_next = cnt_last ? DUP_H_STRB : DUP_H_SETUP;
      DUP_H_STRB:  state_next = cnt_last ? DUP_H_HOLD : DUP_H_STRB;
      DUP_H_HOLD:  state_next = cnt_last ? DUP_H_IDLE : DUP_H_HOLD;
      default:     state_next = DUP_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= DUP_H_IDLE;
      cnt_reg   <= '0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= (state_next != state_reg) ? 8'h00 : cnt_reg + 8'h01;
      if (strb_last && !is_wr_reg) begin
        rdata_reg <= bus.host_data_bus;
      end
    end
  end

  // ----------------------------------------------------------------------
  // bus pins
  // ----------------------------------------------------------------------
  logic act_next;
  logic strb_next;

  assign act_next  = state_next != DUP_H_IDLE;
  assign strb_next = state_next == DUP_H_STRB;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bus.chan_a_select_n       <= 1'b1;
      bus.chan_b_select_n       <= 1'b1;
      bus.printer_port_select_n <= 1'b1;
      bus.addr                  <= '0;
      bus.read_strobe_n         <= 1'b1;
      bus.write_strobe_n        <= 1'b1;
      bus.host_data_out         <= '0;
      bus.host_data_oe_n        <= 1'b1;
      bus.master_reset_n        <= 1'b0;
    end else begin
      bus.chan_a_select_n       <= ~(act_next && tgt == DUP_TGT_A);
      bus.chan_b_select_n       <= ~(act_next && tgt == DUP_TGT_B);
      bus.printer_port_select_n <= ~(act_next && tgt == DUP_TGT_P);
      bus.addr                  <= addr_cfg_reg[DUP_AW-1:0];
      bus.read_strobe_n         <= ~(strb_next && !go_wr_sel());
      bus.write_strobe_n        <= ~(strb_next && go_wr_sel());
      bus.host_data_out         <= wdata_reg;
      bus.host_data_oe_n        <= ~(act_next && go_wr_sel());
      bus.master_reset_n        <= ~addr_cfg_reg[DUP_HR_RST_BIT];
    end
  end

  // direction of the cycle in flight, including its first cycle
  function automatic logic go_wr_sel();
    go_wr_sel = go ? reg_wdata_in[DUP_HR_GO_WR_BIT] : is_wr_reg;
  endfunction : go_wr_sel

endmodule : dup_host

// ---- tb/dup_properties.sv ----
`timescale 1ns/1ns
module dup_properties (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       srst_in,
  // bus signals
  input wire logic       chan_a_select_n,
  input wire logic       chan_b_select_n,
  input wire logic       printer_port_select_n,
  input wire logic [2:0] addr,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       master_reset_n,
  input wire logic [7:0] host_data_out,
  input wire logic       host_data_oe_n,
  input wire logic [7:0] dev_data_out,
  input wire logic       dev_data_oe_n,
  input wire logic       read_active_out,
  input wire logic [7:0] host_data_bus
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  logic [1:0] sel_cnt;
  assign sel_cnt = chan_a_select_n + chan_b_select_n + printer_port_select_n;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  property p_ra; read_active_out == !dev_data_oe_n; endproperty
  a_ra: assert property (p_ra) else $error("read active off drive");
  property p_one; !dev_data_oe_n |-> host_data_oe_n; endproperty
  a_one: assert property (p_one) else $error("bus contention");
  property p_drv; !dev_data_oe_n |-> $past(read_strobe_n, 3) == 1'b0;
  endproperty
  a_drv: assert property (p_drv) else $error("drive without read");
  property p_sel; !dev_data_oe_n |-> $past(sel_cnt, 2) == 2'h2; endproperty
  a_sel: assert property (p_sel) else $error("drive on bad select");
  property p_stb; !read_strobe_n || !write_strobe_n |-> sel_cnt == 2'h2;
  endproperty
  a_stb: assert property (p_stb) else $error("strobe not one select");
  property p_wlen;
    $fell(write_strobe_n) |-> !write_strobe_n [*8] ##[1:3] write_strobe_n;
  endproperty
  a_wlen: assert property (p_wlen) else $error("write strobe len");
  property p_rlen; $fell(read_strobe_n) |-> ##[9:11] $rose(read_strobe_n);
  endproperty
  a_rlen: assert property (p_rlen) else $error("read strobe len");
  property p_wst; !write_strobe_n |-> $stable(addr) && !host_data_oe_n;
  endproperty
  a_wst: assert property (p_wst) else $error("write setup broken");
  property p_rho; !read_strobe_n |-> host_data_oe_n && write_strobe_n;
  endproperty
  a_rho: assert property (p_rho) else $error("host drives on read");
  property p_mr; !master_reset_n [*3] |-> dev_data_oe_n && !read_active_out;
  endproperty
  a_mr: assert property (p_mr) else $error("master reset ignored");
  cover property (!dev_data_oe_n);
  cover property ($fell(write_strobe_n) && !printer_port_select_n);
  cover property (!master_reset_n [*3]);
endmodule : dup_properties

// ---- tb/dual_uart_printer_host_port_tb.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module dual_uart_printer_host_port_tb;
  import dup_pkg::*;
  // ----------------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------------
  logic clk_in, srst_in, reg_wr, reg_rd, dsel, ack_n, busy, din;
  logic pd_oe_n, alf_oe_n, u_wr, u_rd, u_b, u_rst;
  logic [2:0] reg_addr, u_a;
  logic [7:0] reg_wdata, reg_rdata, pin_in, u_rdata, pd_out, u_wd;
  logic [7:0] r, v, pdata, ctrl, pat;
  logic [11:0] cap;
  logic [31:0] seed, rn;
  logic iosel_in;
  int n_fail, total_checks, n_pulse, n0, k;
  dup_bus_if bus ();
  dup_host u_dup_host (.clk_in(clk_in), .srst_in(srst_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .bus(bus));
  dup_dev u_dup_dev (.clk_in(clk_in), .srst_in(srst_in), .bus(bus),
    .direction_source_select_in(dsel), .printer_data_lines_in(pin_in),
    .printer_data_lines_out(pd_out), .printer_data_lines_oe_n_out(pd_oe_n),
    .ack_n_in(ack_n), .busy_in(busy), .auto_line_feed_n_in(1'b1),
    .auto_line_feed_n_out(), .auto_line_feed_n_oe_n_out(alf_oe_n),
    .uart_wr_out(u_wr), .uart_rd_out(u_rd), .uart_chan_b_out(u_b),
    .uart_addr_out(u_a), .uart_wdata_out(u_wd), .uart_rdata_in(u_rdata),
    .uart_reset_out(u_rst));
  dup_properties u_dup_properties (.clk_in(clk_in), .srst_in(srst_in),
    .chan_a_select_n(bus.chan_a_select_n), .addr(bus.addr),
    .chan_b_select_n(bus.chan_b_select_n),
    .printer_port_select_n(bus.printer_port_select_n),
    .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
    .master_reset_n(bus.master_reset_n), .host_data_out(bus.host_data_out),
    .host_data_oe_n(bus.host_data_oe_n), .dev_data_out(bus.dev_data_out),
    .dev_data_oe_n(bus.dev_data_oe_n), .read_active_out(bus.read_active_out),
    .host_data_bus(bus.host_data_bus));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (u_wr === 1'b1 || u_rd === 1'b1) begin
    n_pulse++;
    cap = {u_b, u_a, u_wd};
  end
  // ----------------------------------------------------------------------
  // tasks and sequence
  // ----------------------------------------------------------------------
  task automatic hw(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask : hw
  task automatic hr(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : hr
  task automatic xf(input logic [1:0] t, input logic [2:0] a, input logic w,
                    input logic [7:0] d, output logic [7:0] q);
    logic [7:0] s;
    hw(DUP_HR_ADDR, {3'h0, t, a});
    hw(DUP_HR_WDATA, d);
    hw(DUP_HR_GO, {7'h00, w});
    s = 8'h00;
    for (int i = 0; i < 100 && s[1] !== 1'b1; i++) hr(DUP_HR_STATUS, s);
    `CHK("done", 1'b1, s[1])
    hr(DUP_HR_RDATA, q);
  endtask : xf
  task automatic print_verdict;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end
  initial begin
    {reg_wr, reg_rd, dsel, busy, reg_addr, reg_wdata} = '0;
    {ack_n, pin_in, u_rdata, seed, srst_in} = {1'b1, 16'h0, 32'h65A6, 1'b1};
    {pdata, ctrl, iosel_in} = '0;
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    hr(3'h5, r);
    `CHK("unmapped", 8'h00, r)
    for (k = 0; k < 8; k++) begin
      rn = $random(seed);
      @(posedge clk_in);
      dsel <= k[2];
      {pin_in, busy, ack_n, v} <= rn[17:0];
      xf(DUP_TGT_P, DUP_PP_DATA, 1'b1, rn[7:0], r);
      pdata = rn[7:0];
      pat = k[0] ? DUP_IOSEL_IN : (k[1] ? DUP_IOSEL_OUT : 8'h3C);
      xf(DUP_TGT_P, DUP_PP_IOSEL, 1'b1, pat, r);
      iosel_in = (pat == DUP_IOSEL_IN) ? 1'b1 : (pat == 8'h3C) & iosel_in;
      ctrl = {2'h0, k[1], 3'h0, k[0], 1'b0};
      xf(DUP_TGT_P, DUP_PP_CTRL, 1'b1, ctrl, r);
      din = dsel ? ctrl[DUP_CTRL_DIR_BIT] : iosel_in;
      xf(DUP_TGT_P, DUP_PP_DATA, 1'b0, 8'h00, r);
      `CHK("pdata", din ? pin_in : pdata, r)
      `CHK("pdir", din, pd_oe_n)
      if (!din) `CHK("pd_out", pdata, pd_out)
      `CHK("alf", ~ctrl[DUP_CTRL_ALF_BIT], alf_oe_n)
      xf(DUP_TGT_P, DUP_PP_STAT, 1'b0, 8'h00, r);
      `CHK("stat", {busy, ack_n, 6'h00}, r)
    end
    for (k = 0; k < 16; k++) begin
      rn = $random(seed);
      @(posedge clk_in);
      u_rdata <= rn[15:8];
      n0 = n_pulse;
      xf({1'b0, k[3]}, k[2:0], 1'b1, rn[7:0], r);
      `CHK("uwr", {k[3], k[2:0], rn[7:0]}, cap)
      xf({1'b0, k[3]}, k[2:0], 1'b0, 8'h00, r);
      `CHK("urd", rn[15:8], r)
      `CHK("uaddr", {k[3], k[2:0]}, cap[11:8])
      `CHK("npulse", n0 + 2, n_pulse)
    end
    xf(DUP_TGT_P, DUP_PP_CTRL, 1'b1, 8'h22, r);
    hw(DUP_HR_ADDR, 8'h80);
    repeat (6) @(posedge clk_in);
    `CHK("urst", 1'b1, u_rst)
    hw(DUP_HR_ADDR, 8'h00);
    repeat (6) @(posedge clk_in);
    `CHK("alf_rst", 1'b1, alf_oe_n)
    xf(DUP_TGT_P, DUP_PP_CTRL, 1'b0, 8'h00, r);
    `CHK("ctrl_rst", DUP_CTRL_RST, r)
    print_verdict();
  end
endmodule : dual_uart_printer_host_port_tb
